/* File: dv/eccd_ctl_model.sv */
/* Controller model that presets the counter.
   Assumes go is a one-cycle request from the bench. */
`timescale 1ns/1ns
module eccd_ctl_model
(
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] n,
  output logic cnt_load,
  output logic [7:0] cnt_load_data
);
  initial cnt_load = 1'b0;
  initial cnt_load_data = 8'h00;
  // Data off the strobe is scrambled so a stray capture shows.
  always @(posedge clk)
  begin
    cnt_load <= #1 go;
    cnt_load_data <= #1 go ? 8'h00 - n : ~cnt_load_data;
  end
endmodule

/* File: dv/eccd_props.sv */
/* Port checker for eccd_top.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ns
module eccd_props
(
  input wire logic clk,
  input wire logic reset,
  input wire logic cnt_variant,
  input wire logic cnt_pulse,
  input wire logic cnt_read,
  input wire logic cnt_load,
  input wire logic cnt_irq_clear,
  input wire logic [7:0] chg_in,
  input wire logic [15:0] chg_sense,
  input wire logic chg_clear,
  input wire logic [7:0] cnt_data_ff,
  input wire logic [7:0] cnt_value_ff,
  input wire logic cnt_irq_ff,
  input wire logic cnt_halted_ff,
  input wire logic chg_irq_ff,
  input wire logic [7:0] chg_cause_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_last;
    cnt_variant && cnt_pulse && !cnt_load && !cnt_halted_ff && cnt_value_ff == 8'hff;
  endsequence
  sequence s_ev;
    !cnt_variant && !cnt_read && cnt_pulse;
  endsequence
  AST_CNT: assert property (s_ev |=> cnt_value_ff == $past(cnt_value_ff) + 8'h01)
    else $error("count did not step");
  AST_RDCLR: assert property (!cnt_variant && cnt_read && !cnt_pulse |=>
    cnt_value_ff == 8'h00 && cnt_data_ff == $past(cnt_value_ff)) else $error("read bad");
  AST_HALF: assert property (s_ev ##0 cnt_value_ff == 8'h7f |=> cnt_irq_ff)
    else $error("no half irq");
  AST_STOP: assert property (s_last |=> cnt_halted_ff && cnt_irq_ff && !cnt_value_ff)
    else $error("no stop at zero");
  AST_FALL: assert property (!$past(reset) && chg_sense[1:0] == 2'h1 &&
    $fell(chg_in[0]) |=> chg_irq_ff && chg_cause_ff[0]) else $error("change missed");
  AST_SENSE: assert property (!$past(reset) && chg_sense[1:0] == 2'h1 &&
    $rose(chg_in[0]) && !chg_cause_ff[0] |=> !chg_cause_ff[0]) else $error("wrong edge");
  AST_HOLDC: assert property (cnt_irq_ff && !cnt_read && !cnt_irq_clear && !cnt_load
    |=> cnt_irq_ff) else $error("count irq lost");
  AST_HOLDG: assert property (chg_irq_ff && !chg_clear |=> chg_irq_ff)
    else $error("change irq lost");
endmodule
bind eccd_top eccd_props props_u (.clk, .reset, .cnt_variant, .cnt_pulse, .cnt_read,
  .cnt_load, .cnt_irq_clear, .chg_in, .chg_sense, .chg_clear, .cnt_data_ff,
  .cnt_value_ff, .cnt_irq_ff, .cnt_halted_ff, .chg_irq_ff, .chg_cause_ff);

/* File: dv/tb_event_counter_and_change_detect.sv */
/* Bench for eccd_top with a controller model.
   Assumes the checker is bound by its own file. */
`timescale 1ns/1ns
module tb_event_counter_and_change_detect;
  logic clk = 1'b0, reset = 1'b1, cnt_variant = 1'b0, cnt_pulse = 1'b0, cnt_read = 1'b0;
  logic go = 1'b0, cnt_irq_clear = 1'b0, chg_clear = 1'b0, cnt_load;
  logic [7:0] n = 8'h00, chg_in = 8'h00, cnt_load_data, cnt_data_ff, cnt_value_ff;
  logic [7:0] chg_cause_ff;
  logic [15:0] chg_sense = 16'h5555;
  logic cnt_irq_ff, cnt_halted_ff, chg_irq_ff;
  int miscompares = 0, checks = 0, seed = 32'h3932, m, k, h, j;
  int rd_q[$];
  always #20 clk = ~clk;
  eccd_top dut_u (.clk, .reset, .cnt_variant, .cnt_pulse, .cnt_read, .cnt_load,
    .cnt_load_data, .cnt_irq_clear, .chg_in, .chg_sense, .chg_clear, .cnt_data_ff,
    .cnt_value_ff, .cnt_irq_ff, .cnt_halted_ff, .chg_irq_ff, .chg_cause_ff);
  eccd_ctl_model ctl_u (.clk, .go, .n, .cnt_load, .cnt_load_data);
  task automatic tick(input int c = 1);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic chk_bit(input string s, input logic e, input logic g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s exp %b got %b", s, e, g);
    end
  endtask
  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #40000;
    miscompares++;
    summarize();
  end
  initial
  begin
    tick(8);
    reset = 1'b0;
    m = 0;
    k = 130 + $unsigned($random(seed)) % 20;
    cnt_pulse = 1'b1;
    // The first read sees no pulse, the second one reads on a pulse.
    for (int r = 0; r < 2; r++)
    begin
      repeat (k)
      begin
        tick();
        m = (m + 1) % 256;
        chk("value", m, cnt_value_ff);
        chk_bit("irq", m >= 128, cnt_irq_ff);
      end
      rd_q.push_back(m);
      cnt_read = 1'b1;
      cnt_pulse = (r == 1);
      tick();
      cnt_read = 1'b0;
      cnt_pulse = (r == 0);
      m = r;
      chk("data", rd_q.pop_front(), cnt_data_ff);
      chk("value", m, cnt_value_ff);
      chk_bit("irq", 1'b0, cnt_irq_ff);
    end
    $display("event test done");
    cnt_variant = 1'b1;
    // The second round reloads a counter that is halted with pulses running.
    for (int r = 0; r < 2; r++)
    begin
      n = 8'h01 + $unsigned($random(seed)) % 8;
      go = 1'b1;
      tick();
      go = 1'b0;
      tick();
      m = 256 - n;
      h = 0;
      chk("value", m, cnt_value_ff);
      chk_bit("halt", 1'b0, cnt_halted_ff);
      chk_bit("irq", 1'b0, cnt_irq_ff);
      cnt_pulse = 1'b1;
      repeat (n + 2)
      begin
        tick();
        if (h == 0)
          m = (m + 1) % 256;
        h = (m == 0);
        chk("value", m, cnt_value_ff);
        chk_bit("halt", h, cnt_halted_ff);
        chk_bit("irq", h, cnt_irq_ff);
      end
      cnt_irq_clear = 1'b1;
      tick();
      cnt_irq_clear = 1'b0;
      chk_bit("irq", 1'b0, cnt_irq_ff);
      chk_bit("halt", 1'b1, cnt_halted_ff);
    end
    $display("preset test done");
    k = 1 + $unsigned($random(seed)) % 7;
    j = k % 7 + 1;
    chg_sense[2 * k] = 1'b0;
    chg_sense[2 * j + 1] = 1'b1;
    chg_sense[2 * j] = $random(seed);
    chg_in = 8'hff;
    tick();
    chk("cause", (8'h01 << k) | (8'h01 << j), chg_cause_ff);
    chk_bit("irq", 1'b1, chg_irq_ff);
    chg_clear = 1'b1;
    tick();
    chk("cause", 8'h00, chg_cause_ff);
    chk_bit("irq", 1'b0, chg_irq_ff);
    // The clear is still high when the inputs fall: the new changes win.
    chg_in = 8'h00;
    tick();
    chg_clear = 1'b0;
    chk("cause", ~(8'h01 << k), chg_cause_ff);
    chk_bit("irq", 1'b1, chg_irq_ff);
    $display("change test done");
    summarize();
  end
endmodule

/* File: hw/eccd_change_detect.sv */
/*
  Change-detect card: flags a selected transition on any of eight inputs.
  Assumes inputs synchronous to clk and a static per-input sense setting.
*/
`timescale 1ns/1ns
module eccd_change_detect
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] chg_in,
  input wire logic [15:0] chg_sense,
  input wire logic chg_clear,
  output logic chg_irq_ff,
  output logic [7:0] chg_cause_ff
);

  logic [7:0] prev_ff;
  logic [7:0] hit;

  // ----------------------------------------------------------------
  // Edge test for one input under its sense setting
  // ----------------------------------------------------------------
  function automatic logic edge_hit(input logic old_v, input logic new_v,
                                    input logic [1:0] sense);
    logic rise;
    logic fall;
    rise = ~old_v & new_v;
    fall = old_v & ~new_v;
    if (sense == eccd_pkg::SENSE_RISE)
      edge_hit = rise;
    else if (sense == eccd_pkg::SENSE_FALL)
      edge_hit = fall;
    else
      edge_hit = rise | fall;
  endfunction

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      hit[i] = edge_hit(prev_ff[i], chg_in[i], chg_sense[2*i +: 2]);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      prev_ff <= eccd_pkg::CHG_RESET;
    else
      prev_ff <= chg_in;
  end

  // A new transition in the clearing cycle is kept.
  always_ff @(posedge clk)
  begin
    if (reset)
      chg_cause_ff <= eccd_pkg::CHG_RESET;
    else if (chg_clear)
      chg_cause_ff <= hit;
    else
      chg_cause_ff <= chg_cause_ff | hit;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      chg_irq_ff <= 1'b0;
    else if (|hit)
      chg_irq_ff <= 1'b1;
    else if (chg_clear)
      chg_irq_ff <= 1'b0;
  end

endmodule

/* File: hw/eccd_pkg.sv */
/*
  Package for the event counter and change detect plug-in card logic.
  Holds widths, reset values, variant codes and edge-sense codes.
  Assumes a single 25 MHz clock with a synchronous active-high reset.
*/
package eccd_pkg;

  // ----------------------------------------------------------------
  // Widths and values
  // ----------------------------------------------------------------
  localparam int CNT_W = 8;
  localparam int CHG_W = 8;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] CNT_HALF = 8'h80;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CHG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Counter variants and edge senses
  // ----------------------------------------------------------------
  localparam logic VARIANT_EVENT = 1'b0;
  localparam logic VARIANT_PRESET = 1'b1;
  localparam logic [1:0] SENSE_RISE = 2'h0;
  localparam logic [1:0] SENSE_FALL = 2'h1;
  localparam logic [1:0] SENSE_BOTH = 2'h2;

  typedef enum logic [0:0] {
    CS_COUNT,
    CS_HALTED
  } eccd_cnt_state_e;

endpackage

/* File: hw/eccd_top.sv */
/*
  Event counter and change detect plug-in card logic.
  Holds the eight-bit pulse counter in event or preset variant and
  instantiates the change-detect card. Every output is registered.
  Assumes single-cycle pulses, strobes and loads synchronous to clk,
  a variant and an edge-sense setting that stay fixed while counting,
  and a controller that services each interrupt it is given.
*/
// Notes on behaviour
// - Eight-bit counter counts each input pulse.
// - Event variant: read clears, counting continues.
// - Event variant: interrupt at 128, keep counting.
// - Preset variant: stop and interrupt at zero.
// - Any monitored input change raises interrupt.
// - Static setting selects rise, fall or both.
`timescale 1ns/1ns
module eccd_top
(
  input wire logic clk,
  input wire logic reset,
  input wire logic cnt_variant,
  input wire logic cnt_pulse,
  input wire logic cnt_read,
  input wire logic cnt_load,
  input wire logic [7:0] cnt_load_data,
  input wire logic cnt_irq_clear,
  input wire logic [7:0] chg_in,
  input wire logic [15:0] chg_sense,
  input wire logic chg_clear,
  output logic [7:0] cnt_data_ff,
  output logic [7:0] cnt_value_ff,
  output logic cnt_irq_ff,
  output logic cnt_halted_ff,
  output logic chg_irq_ff,
  output logic [7:0] chg_cause_ff
);

  eccd_pkg::eccd_cnt_state_e state_ff;
  logic [7:0] nxt_cnt;
  logic [7:0] nxt_event_cnt;
  logic [7:0] nxt_preset_cnt;
  logic event_mode;
  logic preset_mode;
  logic counting;
  logic service;
  logic half_hit;
  logic zero_hit;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Both variants step the count the same way, wrapping at full scale.
  function automatic logic [7:0] step_count(input logic [7:0] value);
    step_count = value + 8'h01;
  endfunction

  // Both interrupt causes test the next count against one level.
  function automatic logic count_at(input logic [7:0] value, input logic [7:0] level);
    count_at = (value == level);
  endfunction

  // ----------------------------------------------------------------
  // Mode and strobe decode
  // ----------------------------------------------------------------
  assign event_mode = (cnt_variant == eccd_pkg::VARIANT_EVENT);
  assign preset_mode = (cnt_variant == eccd_pkg::VARIANT_PRESET);
  assign counting = cnt_pulse && (state_ff == eccd_pkg::CS_COUNT);

  // Reading, clearing or reloading all count as servicing the counter.
  assign service = cnt_read || cnt_irq_clear || cnt_load;

  // ----------------------------------------------------------------
  // Event variant next count
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_event_cnt = cnt_value_ff;
    // A pulse in the read cycle is not lost: it starts the new count.
    if (cnt_read)
    begin
      if (counting)
        nxt_event_cnt = step_count(eccd_pkg::CNT_RESET);
      else
        nxt_event_cnt = eccd_pkg::CNT_RESET;
    end
    else if (counting)
    begin
      nxt_event_cnt = step_count(cnt_value_ff);
    end
  end

  // ----------------------------------------------------------------
  // Preset variant next count
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_preset_cnt = cnt_value_ff;
    if (cnt_load)
    begin
      nxt_preset_cnt = cnt_load_data;
    end
    else if (counting)
    begin
      nxt_preset_cnt = step_count(cnt_value_ff);
    end
  end

  always_comb
  begin
    if (event_mode)
      nxt_cnt = nxt_event_cnt;
    else
      nxt_cnt = nxt_preset_cnt;
  end

  // ----------------------------------------------------------------
  // Interrupt causes
  // ----------------------------------------------------------------
  // A read in the crossing cycle restarts the count, so no half-scale event.
  assign half_hit = event_mode && counting && !cnt_read
                    && count_at(nxt_event_cnt, eccd_pkg::CNT_HALF);
  // A load in the reaching cycle wins: the counter is being re-armed.
  assign zero_hit = preset_mode && counting && !cnt_load
                    && count_at(nxt_preset_cnt, eccd_pkg::CNT_ZERO);

  // ----------------------------------------------------------------
  // Count register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cnt_value_ff <= eccd_pkg::CNT_RESET;
    end
    else
    begin
      cnt_value_ff <= nxt_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Read data is the count as held before the read strobe.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cnt_data_ff <= eccd_pkg::CNT_RESET;
    end
    else if (cnt_read)
    begin
      cnt_data_ff <= cnt_value_ff;
    end
  end

  // ----------------------------------------------------------------
  // Preset halt state
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_ff <= eccd_pkg::CS_COUNT;
    end
    else
    begin
      case (state_ff)
        eccd_pkg::CS_COUNT:
        begin
          if (zero_hit)
            state_ff <= eccd_pkg::CS_HALTED;
        end
        eccd_pkg::CS_HALTED:
        begin
          // Only a reload or a change of variant lets counting resume.
          if (cnt_load || event_mode)
            state_ff <= eccd_pkg::CS_COUNT;
        end
        default:
        begin
          state_ff <= eccd_pkg::CS_COUNT;
        end
      endcase
    end
  end

  // The halt flag follows the halted state in a register of its own.
  always_ff @(posedge clk)
  begin
    if (reset)
      cnt_halted_ff <= 1'b0;
    else if (zero_hit)
      cnt_halted_ff <= 1'b1;
    else if (cnt_load || !preset_mode)
      cnt_halted_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Counter interrupt: set wins over service
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      cnt_irq_ff <= 1'b0;
    else if (half_hit)
      cnt_irq_ff <= 1'b1;
    else if (zero_hit)
      cnt_irq_ff <= 1'b1;
    else if (service)
      cnt_irq_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Change-detect card
  // ----------------------------------------------------------------
  eccd_change_detect u_chg
  (
    .clk(clk),
    .reset(reset),
    .chg_in(chg_in),
    .chg_sense(chg_sense),
    .chg_clear(chg_clear),
    .chg_irq_ff(chg_irq_ff),
    .chg_cause_ff(chg_cause_ff)
  );

endmodule
